// >>> rtl/mrl_datapath.sv
// Execution datapath: multiply, rotate and table-latch read
`timescale 1ns/1ps
module mrl_datapath
  import mrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Instruction from decoder, one per cycle when valid
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  // File register read data for the addressed register
  input wire logic [DATA_W-1:0] file_rdata_i,
  // Table latch contents (owned outside)
  input wire logic [DATA_W-1:0] table_latch_high_i,
  input wire logic [DATA_W-1:0] table_latch_low_i,
  // File register write-back
  output logic file_we_o,
  output logic [7:0] file_addr_o,
  output logic [DATA_W-1:0] file_wdata_o,
  // Architectural state held here
  output logic [DATA_W-1:0] working_register_o,
  output logic [DATA_W-1:0] product_high_o,
  output logic [DATA_W-1:0] product_low_o,
  output logic carry_o
);
  // ****************************************
  // Decode
  // ****************************************
  wire is_mul_lit;
  wire is_mul_file;
  wire is_rot_left;
  wire is_rot_right;
  wire is_latch_read;
  wire dest_file;
  wire [DATA_W-1:0] literal;
  wire [DATA_W-1:0] mul_b;
  wire mul_load;
  wire [DATA_W-1:0] rot_left_val;
  wire [DATA_W-1:0] rot_right_val;
  wire [DATA_W-1:0] latch_byte;
  wire rotate;
  wire [DATA_W-1:0] rot_val;
  wire [PROD_W-1:0] product;

  assign is_mul_lit = instr_valid_i && instr_i[15:8] == MULTIPLY_LITERAL_OP_CODE;
  assign is_mul_file = instr_valid_i && instr_i[15:8] == MULTIPLY_FILE_OP_CODE;
  assign is_rot_left = instr_valid_i && instr_i[15:9] == ROTATE_LEFT_NOCARRY_OP_CODE;
  assign is_rot_right = instr_valid_i && instr_i[15:9] == ROTATE_RIGHT_CARRY_OP_CODE;
  assign is_latch_read = instr_valid_i && instr_i[15:10] == LATCH_READ_OP_CODE;
  assign dest_file = instr_i[DEST_BIT] != DEST_WORKING;
  assign literal = instr_i[7:0];

  // ****************************************
  // Multiply
  // ****************************************
  assign mul_load = is_mul_lit || is_mul_file;
  assign mul_b = is_mul_lit ? literal : file_rdata_i;

  mrl_multiplier u_mult (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .load_i(mul_load),
    .op_a_i(working_register_o),
    .op_b_i(mul_b),
    .product_o(product)
  );
  assign product_high_o = product[15:8];
  assign product_low_o = product[7:0];

  // ****************************************
  // Rotate and latch select
  // ****************************************
  assign rot_left_val = {file_rdata_i[6:0], file_rdata_i[7]};
  assign rot_right_val = {carry_o, file_rdata_i[7:1]};
  assign rotate = is_rot_left || is_rot_right;
  assign rot_val = is_rot_left ? rot_left_val : rot_right_val;
  // Latch is only read here; no path writes it back
  assign latch_byte = (instr_i[BYTE_SEL_BIT] == BYTE_SEL_HIGH) ?
                      table_latch_high_i : table_latch_low_i;

  // ****************************************
  // State and write-back
  // ****************************************
  // Working register only changes on rotate to W; multiplies never touch it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      working_register_o <= WORKING_RESET;
    end else if (rotate && !dest_file) begin
      working_register_o <= rot_val;
    end
  end

  // Carry moves only on rotate right; multiplies keep all flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_o <= CARRY_RESET;
    end else if (is_rot_right) begin
      carry_o <= file_rdata_i[0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      file_we_o <= 1'b0;
      file_addr_o <= 8'h00;
      file_wdata_o <= 8'h00;
    end else begin
      file_we_o <= (rotate && dest_file) || is_latch_read;
      file_addr_o <= instr_i[7:0];
      file_wdata_o <= is_latch_read ? latch_byte : rot_val;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence mul_lit_issued;
    is_mul_lit;
  endsequence

  mul_literal_product_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mul_lit_issued |=> {product_high_o, product_low_o} ==
      PROD_W'($past(working_register_o)) * PROD_W'($past(instr_i[7:0])))
    else $error("literal multiply product wrong");

  mul_file_product_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_mul_file |=> product == PROD_W'($past(working_register_o)) * PROD_W'($past(file_rdata_i)))
    else $error("file multiply product wrong");

  mul_keeps_w_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mul_load |=> $stable(working_register_o) && !file_we_o)
    else $error("multiply disturbed working register or file");

  mul_keeps_carry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mul_load |=> $stable(carry_o))
    else $error("multiply changed carry");

  rot_left_value_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_rot_left && dest_file |=> file_we_o &&
      file_wdata_o == {$past(file_rdata_i[6:0]), $past(file_rdata_i[7])} && $stable(carry_o))
    else $error("rotate left result wrong");

  rot_right_carry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_rot_right && !dest_file |=> carry_o == $past(file_rdata_i[0]) &&
      working_register_o == {$past(carry_o), $past(file_rdata_i[7:1])} && !file_we_o)
    else $error("rotate right through carry wrong");

  latch_read_high_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_latch_read && instr_i[BYTE_SEL_BIT] |=> file_we_o &&
      file_wdata_o == $past(table_latch_high_i))
    else $error("latch high byte not selected");

  latch_read_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_latch_read && !instr_i[BYTE_SEL_BIT] |=> file_we_o &&
      file_wdata_o == $past(table_latch_low_i) && file_addr_o == $past(instr_i[7:0]))
    else $error("latch low byte read wrong");

  // ****************************************
  // Checks on held state
  // ****************************************
  sequence rot_to_working;
    rotate && !dest_file;
  endsequence

  sequence rot_to_file;
    rotate && dest_file;
  endsequence

  sequence file_write_issued;
    (rotate && dest_file) || is_latch_read;
  endsequence

  rot_left_working_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_rot_left && !dest_file |=> !file_we_o && $stable(carry_o) &&
      working_register_o == {$past(file_rdata_i[6:0]), $past(file_rdata_i[7])})
    else $error("rotate left into working register wrong");

  rot_right_file_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_rot_right && dest_file |=> file_we_o && carry_o == $past(file_rdata_i[0]) &&
      file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])} && $stable(working_register_o))
    else $error("rotate right into file register wrong");

  rot_keeps_file_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rot_to_working |=> !file_we_o && $stable(product))
    else $error("rotate into working register touched file or product");

  rot_file_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rot_to_file |=> file_we_o && $stable(working_register_o) && $stable(product))
    else $error("rotate into file register missed write or touched working");

  write_target_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    file_write_issued |=> file_we_o && file_addr_o == $past(instr_i[7:0]))
    else $error("write-back missing or at wrong address");

  no_stray_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !((rotate && dest_file) || is_latch_read) |=> !file_we_o)
    else $error("file written without a write-back instruction");

  working_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(rotate && !dest_file) |=> $stable(working_register_o))
    else $error("working register changed without a rotate into it");

  carry_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !is_rot_right |=> $stable(carry_o))
    else $error("carry changed outside rotate right");

  product_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !mul_load |=> $stable(product))
    else $error("product changed without a multiply");

  latch_read_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_latch_read |=> $stable(working_register_o) && $stable(carry_o) && $stable(product))
    else $error("latch read disturbed working, carry or product");
endmodule // mrl_datapath

// >>> rtl/mrl_multiplier.sv
// Unsigned 8x8 multiplier, registered
`timescale 1ns/1ps
module mrl_multiplier
  import mrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Operands
  input wire logic load_i,
  input wire logic [DATA_W-1:0] op_a_i,
  input wire logic [DATA_W-1:0] op_b_i,
  // Result
  output logic [PROD_W-1:0] product_o
);
  wire [PROD_W-1:0] next_product;

  // Unsigned: both operands zero-extended, so no overflow is possible
  assign next_product = PROD_W'(op_a_i) * PROD_W'(op_b_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      product_o <= PRODUCT_RESET;
    end else if (load_i) begin
      product_o <= next_product;
    end
  end
endmodule // mrl_multiplier

// >>> rtl/mrl_pkg.sv
// Package: opcode fields and widths for the multiply/rotate/latch datapath
package mrl_pkg;
  localparam int DATA_W = 8;
  localparam int PROD_W = 16;
  // Top byte (bits 15:8) selecting each operation
  localparam logic [7:0] MULTIPLY_LITERAL_OP_CODE = 8'hbc;
  localparam logic [7:0] MULTIPLY_FILE_OP_CODE = 8'h34;
  // Top seven bits (bits 15:9); bit 8 is the destination bit
  localparam logic [6:0] ROTATE_LEFT_NOCARRY_OP_CODE = 7'h11;
  localparam logic [6:0] ROTATE_RIGHT_CARRY_OP_CODE = 7'h0c;
  // Top six bits (bits 15:10); bit 9 picks the byte, bit 8 is unused
  localparam logic [5:0] LATCH_READ_OP_CODE = 6'h28;
  // Field positions
  localparam int DEST_BIT = 8;
  localparam int BYTE_SEL_BIT = 9;
  localparam logic DEST_WORKING = 1'b0;
  localparam logic BYTE_SEL_HIGH = 1'b1;
  // Reset values
  localparam logic [15:0] PRODUCT_RESET = 16'h0000;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
endpackage : mrl_pkg

// >>> sim/mrl_regfile_model.sv
// Behavioural register file standing at the far side of the datapath
`timescale 1ns/1ps
module mrl_regfile_model (
  // Clock
  input wire logic clk_sys_i,
  // Combinational read port
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o,
  // Write-back port
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem [256];
  // Each register starts at its own address, so expected values stay easy to derive
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end
  assign rdata_o = mem[raddr_i];
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule // mrl_regfile_model

// >>> sim/multiply_rotate_latch_ops_tb.sv
// Self-checking bench for the multiply, rotate and latch-read datapath
`timescale 1ns/1ps
module multiply_rotate_latch_ops_tb;
  typedef struct packed {
    logic v;
    logic [15:0] ins;
    logic we;
    logic [7:0] wd;
    logic [7:0] w;
    logic [15:0] p;
    logic c;
  } row_t;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [7:0] file_rdata, waddr, wdata, w, ph, pl;
  logic we, c;
  logic [7:0] latch_high = 8'hab;
  logic [7:0] latch_low = 8'hcd;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  row_t rows [11];
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  mrl_datapath u_mrl_datapath (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .file_rdata_i(file_rdata),
    .table_latch_high_i(latch_high), .table_latch_low_i(latch_low), .file_we_o(we),
    .file_addr_o(waddr), .file_wdata_o(wdata), .working_register_o(w),
    .product_high_o(ph), .product_low_o(pl), .carry_o(c));
  mrl_regfile_model u_mrl_regfile_model (.clk_sys_i(clk_sys_i), .raddr_i(instr_i[7:0]),
    .rdata_o(file_rdata), .we_i(we), .waddr_i(waddr), .wdata_i(wdata));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic issue(input logic v, input logic [15:0] ins);
    @(negedge clk_sys_i);
    instr_valid_i = v;
    instr_i = ins;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs well under 100 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    rows = '{'{1, 16'h2271, 0, 8'h00, 8'he2, 16'h0000, 0},
      '{1, 16'hbcc4, 0, 8'h00, 8'he2, 16'had08, 0},
      '{1, 16'h3400, 0, 8'h00, 8'he2, 16'h0000, 0}, '{1, 16'h190b, 1, 8'h05, 8'he2, 16'h0000, 1},
      '{1, 16'h1802, 0, 8'h00, 8'h81, 16'h0000, 0}, '{1, 16'h34b5, 0, 8'h00, 8'h81, 16'h5b35, 0},
      '{1, 16'ha310, 1, 8'hab, 8'h81, 16'h5b35, 0}, '{1, 16'ha010, 1, 8'hcd, 8'h81, 16'h5b35, 0},
      '{1, 16'h23eb, 1, 8'hd7, 8'h81, 16'h5b35, 0}, '{0, 16'hbc02, 0, 8'h00, 8'h81, 16'h5b35, 0},
      '{1, 16'hffff, 0, 8'h00, 8'h81, 16'h5b35, 0}};
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check("reset state", {ph, pl}, 16'h0000);
    check("reset working", 16'(w), 16'h0000);
    check("reset carry", 16'(c), 16'h0000);
    // ****************************************
    // Table of single instructions
    // ****************************************
    foreach (rows[i]) begin
      issue(rows[i].v, rows[i].ins);
      issue(1'b0, 16'h0000);
      check("write enable", 16'(we), 16'(rows[i].we));
      if (rows[i].we) begin
        check("write data", 16'(wdata), 16'(rows[i].wd));
        check("write address", 16'(waddr), 16'(rows[i].ins[7:0]));
      end
      check("working", 16'(w), 16'(rows[i].w));
      check("product", {ph, pl}, rows[i].p);
      check("carry", 16'(c), 16'(rows[i].c));
      $display("row %0d done", i);
    end
    // Back to back: the multiply must see the rotated working register
    issue(1'b1, 16'h2201);
    issue(1'b1, 16'hbcff);
    issue(1'b0, 16'h0000);
    check("chained working", 16'(w), 16'h0002);
    check("chained product", {ph, pl}, 16'h01fe);
    $display("back to back done");
    // Reset in mid-run clears the architectural state
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    check("mid-run reset working", 16'(w), 16'h0000);
    check("mid-run reset product", {ph, pl}, 16'h0000);
    check("mid-run reset carry", 16'(c), 16'h0000);
    check("mid-run reset write enable", 16'(we), 16'h0000);
    // Instruction presented at release is taken on the first edge
    rst_n_i = 1'b1;
    instr_valid_i = 1'b1;
    instr_i = 16'h1803;
    issue(1'b1, 16'hbc07);
    check("first working", 16'(w), 16'h0001);
    check("first carry", 16'(c), 16'h0001);
    issue(1'b1, 16'h3400);
    check("product with carry set", {ph, pl}, 16'h0007);
    check("carry kept by multiply", 16'(c), 16'h0001);
    issue(1'b0, 16'h0000);
    check("zero product", {ph, pl}, 16'h0000);
    check("carry kept on zero", 16'(c), 16'h0001);
    check("working kept by multiply", 16'(w), 16'h0001);
    $display("mid-run reset done");
    // New latch bytes: selection must follow the inputs
    latch_high = 8'h00;
    latch_low = 8'haf;
    issue(1'b1, 16'ha020);
    issue(1'b1, 16'ha221);
    check("latch low read", 16'(wdata), 16'h00af);
    check("latch low address", 16'(waddr), 16'h0020);
    issue(1'b0, 16'h0000);
    check("latch high read", 16'(wdata), 16'h0000);
    check("latch high enable", 16'(we), 16'h0001);
    $display("latch bytes done");
    tally_and_finish();
  end
endmodule // multiply_rotate_latch_ops_tb
